//--- shared/timer_irq_pkg.sv
package timer_irq_pkg;
    // Zero-page register offsets
    localparam logic [7:0] ADDR_PRE12 = 8'hF9;
    localparam logic [7:0] ADDR_T1 = 8'hFA;
    localparam logic [7:0] ADDR_T2 = 8'hFB;
    localparam logic [7:0] ADDR_PREX = 8'hFC;
    localparam logic [7:0] ADDR_TX = 8'hFD;
    localparam logic [7:0] ADDR_ICR = 8'hFE;
    localparam logic [7:0] ADDR_TCR = 8'hFF;
    // Interrupt enable/request register fields
    localparam int ICR_COUNTER_PIN_REQ = 7;
    localparam int ICR_COUNTER_PIN_EN = 6;
    localparam int ICR_TX_REQ = 5;
    localparam int ICR_TX_EN = 4;
    localparam int ICR_INT_REQ = 1;
    localparam int ICR_INT_EN = 0;
    // Timer mode control register fields
    localparam int TCR_T1_REQ = 0;
    localparam int TCR_T2_REQ = 1;
    localparam int TCR_MODE_LO = 2;
    localparam int TCR_MODE_HI = 3;
    localparam int TCR_STOP = 5;
    localparam int TCR_T1_EN = 6;
    localparam int TCR_T2_EN = 7;
    // Reset values
    localparam logic [7:0] PREX_RST = 8'hFF;
    localparam logic [7:0] TX_RST = 8'h01;
    localparam logic [7:0] T12_RST = 8'hFF;
    localparam logic [7:0] ICR_RST = 8'h00;
    localparam logic [7:0] TCR_RST = 8'h00;
    // Oscillator divider for the timer X base clock
    localparam logic [3:0] DIV16_LAST = 4'hF;
    // Vector low-byte addresses; the high byte sits one above
    localparam logic [15:0] VEC_RESET = 16'h1FFE;
    localparam logic [15:0] VEC_COUNTER_PIN = 16'h1FFC;
    localparam logic [15:0] VEC_TX = 16'h1FFA;
    localparam logic [15:0] VEC_T1 = 16'h1FF8;
    localparam logic [15:0] VEC_T2 = 16'h1FF6;
    localparam logic [15:0] VEC_INT = 16'h1FF4;
    // Least reset low time and its cycle count at 100 MHz
    localparam int RESET_LOW_NS = 2000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int RESET_LOW_CYCLES = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Timer X operating modes
    typedef enum logic [1:0] {MODE_TIMER, MODE_PULSE, MODE_EVENT, MODE_WIDTH} tx_mode_type;
endpackage : timer_irq_pkg

//--- logic/timer_irq_unit.sv
`timescale 1ns/1ps
// Contract
// R1 - Fixed priority vectors, reset highest, pin lowest
// R2 - Accept: set mask, vector, clear request
// R3 - Accept needs enable, request, mask clear
// R4 - Reset never blocked; mask blocks others
// R5 - Falling pin edges, timer zero set requests
// R6 - Software clears requests only; enables free
// R7 - Timer X mode in control bits 3:2
// R8 - Stop bit 5 halts timer X
// R9 - Shared prescaler divides by n plus two
// R10 - Down counters reload latch after zero
// R11 - Timer zero sets its request bit
// R12 - Software loads only nonzero latch values
// R13 - Mode 00 counts oscillator over sixteen
// R14 - Mode 01 toggles counter pin at zero
// R15 - Mode 10 counts counter pin events
// R16 - Mode 11 counts only while pin low
// R17 - Reset or stop loads FF and 01
// R18 - Stop forces divide-by-16 until request; the logic holds it until timer X reaches zero
// R19 - Reset low 2us; then reset vector
// R20 - After reset registers 00, mask 1
// R21 - Counter pin request at bit 7
// R22 - External pin request at bit 1
// R23 - Clock withheld after stop until overflow
// R24 - Remaining enable/request bits placed consistently
module timer_irq_unit (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic COUNTER_PIN_IN,
    output logic COUNTER_PIN_OUT,
    output logic COUNTER_PIN_OE,
    input wire logic INT_PIN_IN,
    input wire logic IRQ_TAKE,
    input wire logic BREAK_EXEC,
    input wire logic STOP_EXEC,
    input wire logic MASK_SET,
    input wire logic MASK_CLEAR,
    output logic IRQ_REQUEST,
    output logic [15:0] VECTOR_ADDR,
    output logic VECTOR_STROBE,
    output logic MASK_FLAG,
    output logic CORE_CLOCK_HOLD
);
    // Pin synchronisers; stage one feeds only stage two
    logic counter_pin_s1_reg, counter_pin_s2_reg, counter_pin_s3_reg;
    logic int_s1_reg, int_s2_reg, int_s3_reg;
    logic counter_pin_fall, int_fall; // One-cycle falling edge pulses
    // Control and status registers
    logic [7:0] icr_reg, tcr_reg, prex_latch_reg, prex_cnt_reg, pre12_latch_reg;
    logic [8:0] pre12_cnt_reg; // One bit wider to hold n+1
    logic [3:0] div16_reg; // Oscillator over sixteen
    logic div16_tick, prex_in, prex_out, pre12_out; // Count enables
    logic wr_icr, wr_tcr; // Control register write strobes
    logic stop_force_reg, osc_run_reg; // Divide-by-16 forced after stop; oscillator running
    logic tone_reg, reset_pend_reg; // Pulse output level; reset vector still due
    timer_irq_pkg::tx_mode_type tx_mode;
    // Per-timer views: 0 timer X, 1 timer 1, 2 timer 2
    logic [2:0] tmr_tick, tmr_zero, tmr_wr;
    logic [7:0] tmr_cnt [3];
    logic [4:0] pend, grant; // counter_pin, tx, t1, t2, int in priority order

    assign tx_mode = timer_irq_pkg::tx_mode_type'(
        tcr_reg[timer_irq_pkg::TCR_MODE_HI:timer_irq_pkg::TCR_MODE_LO]); // R7
    assign wr_icr = REG_WR && REG_ADDR == timer_irq_pkg::ADDR_ICR;
    assign wr_tcr = REG_WR && REG_ADDR == timer_irq_pkg::ADDR_TCR;
    assign counter_pin_fall = counter_pin_s3_reg && !counter_pin_s2_reg; // R5
    assign int_fall = int_s3_reg && !int_s2_reg; // R5

    // Two-flop synchronisers plus one delay stage for edge detection
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            {counter_pin_s1_reg, counter_pin_s2_reg, counter_pin_s3_reg} <= 3'h7;
            {int_s1_reg, int_s2_reg, int_s3_reg} <= 3'h7;
        end else if (CLK_EN) begin
            {counter_pin_s1_reg, counter_pin_s2_reg, counter_pin_s3_reg} <= {COUNTER_PIN_IN, counter_pin_s1_reg, counter_pin_s2_reg};
            {int_s1_reg, int_s2_reg, int_s3_reg} <= {INT_PIN_IN, int_s1_reg, int_s2_reg};
        end
    end

    // Oscillator divide-by-16; frozen while the oscillator is stopped
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            div16_reg <= 4'h0;
        end else if (CLK_EN && osc_run_reg) begin
            div16_reg <= div16_reg + 4'h1;
        end
    end
    assign div16_tick = osc_run_reg && div16_reg == timer_irq_pkg::DIV16_LAST;

    // Timer X source select; stop forces the divided clock
    always_comb begin
        prex_in = 1'b0;
        if (tcr_reg[timer_irq_pkg::TCR_STOP]) begin
            prex_in = 1'b0; // R8
        end else if (stop_force_reg) begin
            prex_in = div16_tick; // R18
        end else begin
            unique case (tx_mode)
                timer_irq_pkg::MODE_TIMER: prex_in = div16_tick; // R13
                timer_irq_pkg::MODE_PULSE: prex_in = div16_tick; // R14
                timer_irq_pkg::MODE_EVENT: prex_in = counter_pin_fall; // R15
                timer_irq_pkg::MODE_WIDTH: prex_in = div16_tick && !counter_pin_s2_reg; // R16
            endcase
        end
    end

    // Prescaler X: counts down, reloads after zero
    assign prex_out = prex_in && prex_cnt_reg == 8'h00;
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            prex_latch_reg <= timer_irq_pkg::PREX_RST; // R17
            prex_cnt_reg <= timer_irq_pkg::PREX_RST;
        end else if (CLK_EN) begin
            if (STOP_EXEC) begin
                prex_latch_reg <= timer_irq_pkg::PREX_RST; // R17
                prex_cnt_reg <= timer_irq_pkg::PREX_RST;
            end else if (REG_WR && REG_ADDR == timer_irq_pkg::ADDR_PREX) begin
                prex_latch_reg <= REG_WDATA;
                prex_cnt_reg <= REG_WDATA;
            end else if (prex_in) begin
                prex_cnt_reg <= prex_out ? prex_latch_reg : prex_cnt_reg - 8'h01;
            end
        end
    end

    // Shared prescaler for timers 1 and 2; extra state gives n+2
    assign pre12_out = div16_tick && pre12_cnt_reg == 9'h000;
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            pre12_latch_reg <= timer_irq_pkg::T12_RST;
            pre12_cnt_reg <= {1'b0, timer_irq_pkg::T12_RST};
        end else if (CLK_EN) begin
            if (REG_WR && REG_ADDR == timer_irq_pkg::ADDR_PRE12) begin
                pre12_latch_reg <= REG_WDATA;
                pre12_cnt_reg <= {1'b0, REG_WDATA} + 9'h001;
            end else if (div16_tick) begin
                pre12_cnt_reg <= pre12_out ? {1'b0, pre12_latch_reg} + 9'h001 // R9
                                           : pre12_cnt_reg - 9'h001;
            end
        end
    end

    assign tmr_tick = {pre12_out, pre12_out, prex_out};
    assign tmr_wr[0] = REG_WR && REG_ADDR == timer_irq_pkg::ADDR_TX;
    assign tmr_wr[1] = REG_WR && REG_ADDR == timer_irq_pkg::ADDR_T1;
    assign tmr_wr[2] = REG_WR && REG_ADDR == timer_irq_pkg::ADDR_T2;

    // Three down counters with reload latches; zero pulse on reaching 0
    for (genvar i = 0; i < 3; i++) begin : g_tmr
        logic [7:0] latch_reg, cnt_reg;
        logic zero_reg; // Counter sits at zero, reload due
        always_ff @(posedge SYS_CLK) begin
            if (!RST_N) begin
                latch_reg <= (i == 0) ? timer_irq_pkg::TX_RST : timer_irq_pkg::T12_RST; // R17
                cnt_reg <= (i == 0) ? timer_irq_pkg::TX_RST : timer_irq_pkg::T12_RST;
                zero_reg <= 1'b0;
            end else if (CLK_EN) begin
                if (i == 0 && STOP_EXEC) begin
                    latch_reg <= timer_irq_pkg::TX_RST; // R17
                    cnt_reg <= timer_irq_pkg::TX_RST;
                    zero_reg <= 1'b0;
                end else if (tmr_wr[i]) begin
                    // Writing zero here wraps the count to FF, so 256 ticks pass before zero; software avoids it
                    latch_reg <= REG_WDATA; // R12
                    cnt_reg <= REG_WDATA;
                    zero_reg <= 1'b0;
                end else if (tmr_tick[i]) begin
                    if (zero_reg) begin
                        cnt_reg <= latch_reg; // R10
                        zero_reg <= 1'b0;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                        zero_reg <= cnt_reg == 8'h01;
                    end
                end
            end
        end
        assign tmr_zero[i] = tmr_tick[i] && !zero_reg && cnt_reg == 8'h01; // R10
        assign tmr_cnt[i] = cnt_reg;
    end

    // Pending sources gated by enables, highest priority first
    assign pend = {icr_reg[timer_irq_pkg::ICR_COUNTER_PIN_REQ] & icr_reg[timer_irq_pkg::ICR_COUNTER_PIN_EN],
                   icr_reg[timer_irq_pkg::ICR_TX_REQ] & icr_reg[timer_irq_pkg::ICR_TX_EN],
                   tcr_reg[timer_irq_pkg::TCR_T1_REQ] & tcr_reg[timer_irq_pkg::TCR_T1_EN],
                   tcr_reg[timer_irq_pkg::TCR_T2_REQ] & tcr_reg[timer_irq_pkg::TCR_T2_EN],
                   icr_reg[timer_irq_pkg::ICR_INT_REQ] & icr_reg[timer_irq_pkg::ICR_INT_EN]};
    assign IRQ_REQUEST = |pend && !MASK_FLAG && !reset_pend_reg; // R3 R4
    // Grant only the highest pending source on an accepted request
    always_comb begin
        grant = 5'h00;
        if (IRQ_TAKE && IRQ_REQUEST) begin
            if (pend[4]) grant = 5'h10; // R1
            else if (pend[3]) grant = 5'h08;
            else if (pend[2]) grant = 5'h04;
            else if (pend[1]) grant = 5'h02;
            else grant = 5'h01;
        end
    end

    // Interrupt register: hardware set beats software clear
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            icr_reg <= timer_irq_pkg::ICR_RST; // R20
        end else if (CLK_EN) begin
            logic [7:0] v;
            v = icr_reg;
            if (wr_icr) begin
                v[timer_irq_pkg::ICR_COUNTER_PIN_EN] = REG_WDATA[timer_irq_pkg::ICR_COUNTER_PIN_EN]; // R6
                v[timer_irq_pkg::ICR_TX_EN] = REG_WDATA[timer_irq_pkg::ICR_TX_EN];
                v[timer_irq_pkg::ICR_INT_EN] = REG_WDATA[timer_irq_pkg::ICR_INT_EN];
                v[timer_irq_pkg::ICR_COUNTER_PIN_REQ] &= REG_WDATA[timer_irq_pkg::ICR_COUNTER_PIN_REQ]; // R6
                v[timer_irq_pkg::ICR_TX_REQ] &= REG_WDATA[timer_irq_pkg::ICR_TX_REQ];
                v[timer_irq_pkg::ICR_INT_REQ] &= REG_WDATA[timer_irq_pkg::ICR_INT_REQ];
            end
            v[timer_irq_pkg::ICR_COUNTER_PIN_REQ] &= !grant[4]; // R2
            v[timer_irq_pkg::ICR_TX_REQ] &= !grant[3];
            v[timer_irq_pkg::ICR_INT_REQ] &= !grant[0];
            v[timer_irq_pkg::ICR_COUNTER_PIN_REQ] |= counter_pin_fall; // R5 R21
            v[timer_irq_pkg::ICR_TX_REQ] |= tmr_zero[0]; // R11
            v[timer_irq_pkg::ICR_INT_REQ] |= int_fall; // R22
            icr_reg <= v & 8'hF3; // R24
        end
    end

    // Timer control register: mode, stop, timer 1/2 enables and requests
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            tcr_reg <= timer_irq_pkg::TCR_RST; // R20
        end else if (CLK_EN) begin
            logic [7:0] v;
            v = tcr_reg;
            if (wr_tcr) begin
                v[7:2] = REG_WDATA[7:2]; // R6 R7 R8
                v[timer_irq_pkg::TCR_T1_REQ] &= REG_WDATA[timer_irq_pkg::TCR_T1_REQ];
                v[timer_irq_pkg::TCR_T2_REQ] &= REG_WDATA[timer_irq_pkg::TCR_T2_REQ];
            end
            v[timer_irq_pkg::TCR_T1_REQ] &= !grant[2]; // R2
            v[timer_irq_pkg::TCR_T2_REQ] &= !grant[1];
            v[timer_irq_pkg::TCR_T1_REQ] |= tmr_zero[1]; // R11
            v[timer_irq_pkg::TCR_T2_REQ] |= tmr_zero[2]; // R11
            tcr_reg <= v & 8'hEF; // R24
        end
    end

    // Stop sequence: oscillator halts, restarts on a pending enabled
    // request, core clock held until timer X overflows
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            stop_force_reg <= 1'b0; // R18
            osc_run_reg <= 1'b1;
            CORE_CLOCK_HOLD <= 1'b0;
        end else if (CLK_EN) begin
            if (STOP_EXEC) begin
                stop_force_reg <= 1'b1; // R18
                osc_run_reg <= 1'b0;
                CORE_CLOCK_HOLD <= 1'b1; // R23
            end else begin
                if (|pend) osc_run_reg <= 1'b1; // R23
                if (tmr_zero[0]) begin
                    stop_force_reg <= 1'b0; // R18
                    CORE_CLOCK_HOLD <= 1'b0; // R23
                end
            end
        end
    end

    // Pulse output: pin driven only in pulse mode, toggled at zero
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            tone_reg <= 1'b0;
            COUNTER_PIN_OE <= 1'b0;
        end else if (CLK_EN) begin
            COUNTER_PIN_OE <= tx_mode == timer_irq_pkg::MODE_PULSE;
            if (tmr_zero[0] && tx_mode == timer_irq_pkg::MODE_PULSE) tone_reg <= !tone_reg; // R14
        end
    end
    assign COUNTER_PIN_OUT = tone_reg;

    // Mask flag and vectoring; reset vector comes first, break shares
    // the lowest vector and is not gated by the mask
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            MASK_FLAG <= 1'b1; // R20
            reset_pend_reg <= 1'b1; // R19
            VECTOR_ADDR <= timer_irq_pkg::VEC_RESET;
            VECTOR_STROBE <= 1'b0;
        end else if (CLK_EN) begin
            VECTOR_STROBE <= 1'b0;
            if (reset_pend_reg) begin
                reset_pend_reg <= 1'b0;
                VECTOR_ADDR <= timer_irq_pkg::VEC_RESET; // R1 R19
                VECTOR_STROBE <= 1'b1;
            end else if (|grant || BREAK_EXEC) begin
                MASK_FLAG <= 1'b1; // R2
                VECTOR_STROBE <= 1'b1;
                if (grant[4]) VECTOR_ADDR <= timer_irq_pkg::VEC_COUNTER_PIN; // R1
                else if (grant[3]) VECTOR_ADDR <= timer_irq_pkg::VEC_TX;
                else if (grant[2]) VECTOR_ADDR <= timer_irq_pkg::VEC_T1;
                else if (grant[1]) VECTOR_ADDR <= timer_irq_pkg::VEC_T2;
                else VECTOR_ADDR <= timer_irq_pkg::VEC_INT;
            end else if (MASK_SET || MASK_CLEAR) begin
                MASK_FLAG <= MASK_SET; // Set wins when both strobes meet
            end
        end
    end

    // Read data one cycle after the strobe; counters read live, the shared prescaler reads its latch
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            REG_RDATA <= 8'h00;
        end else if (CLK_EN) begin
            REG_RDATA <= 8'h00;
            if (REG_RD) begin
                unique case (REG_ADDR)
                    timer_irq_pkg::ADDR_PRE12: REG_RDATA <= pre12_latch_reg;
                    timer_irq_pkg::ADDR_T1: REG_RDATA <= tmr_cnt[1];
                    timer_irq_pkg::ADDR_T2: REG_RDATA <= tmr_cnt[2];
                    timer_irq_pkg::ADDR_PREX: REG_RDATA <= prex_cnt_reg;
                    timer_irq_pkg::ADDR_TX: REG_RDATA <= tmr_cnt[0];
                    timer_irq_pkg::ADDR_ICR: REG_RDATA <= icr_reg;
                    timer_irq_pkg::ADDR_TCR: REG_RDATA <= tcr_reg;
                    default: REG_RDATA <= 8'h00;
                endcase
            end
        end
    end

    // Checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    sequence accept_s;
        CLK_EN && IRQ_TAKE && IRQ_REQUEST;
    endsequence
    accept_mask_a: assert property (accept_s |=> MASK_FLAG && VECTOR_STROBE) // R2
        else $error("accept did not set mask and vector");
    masked_quiet_a: assert property (MASK_FLAG |-> !IRQ_REQUEST) // R4
        else $error("request raised while masked");
    needs_enable_a: assert property (IRQ_REQUEST |-> |pend) // R3
        else $error("request without enabled pending source");
    counter_pin_prio_a: assert property (accept_s ##0 pend[4] // R1
        |=> VECTOR_ADDR == timer_irq_pkg::VEC_COUNTER_PIN
            && (!icr_reg[timer_irq_pkg::ICR_COUNTER_PIN_REQ] || $past(counter_pin_fall)))
        else $error("counter pin vector wrong");
    int_edge_a: assert property (CLK_EN && int_fall |=> icr_reg[timer_irq_pkg::ICR_INT_REQ]) // R22
        else $error("external pin edge lost");
    tx_zero_req_a: assert property (CLK_EN && tmr_zero[0]
        |=> icr_reg[timer_irq_pkg::ICR_TX_REQ] && tmr_cnt[0] == 8'h00) // R11
        else $error("timer X zero did not set request");
    sw_no_set_a: assert property (CLK_EN && wr_tcr && !tcr_reg[timer_irq_pkg::TCR_T1_REQ]
        && !tmr_zero[1] |=> !tcr_reg[timer_irq_pkg::TCR_T1_REQ]) // R6
        else $error("software set a request bit");
    stop_halt_a: assert property (tcr_reg[timer_irq_pkg::TCR_STOP] && CLK_EN && !REG_WR
        && !STOP_EXEC |=> $stable(prex_cnt_reg)) // R8
        else $error("timer X moved while stopped");
    stop_load_a: assert property (CLK_EN && STOP_EXEC
        |=> prex_cnt_reg == timer_irq_pkg::PREX_RST && tmr_cnt[0] == timer_irq_pkg::TX_RST
            && CORE_CLOCK_HOLD) // R17
        else $error("stop did not load timer X");
    pulse_flip_a: assert property (CLK_EN && tmr_zero[0] && tx_mode == timer_irq_pkg::MODE_PULSE
        |=> COUNTER_PIN_OUT != $past(COUNTER_PIN_OUT)) // R14
        else $error("pulse output did not toggle");
endmodule : timer_irq_unit

//--- bench/pin_partner.sv
`timescale 1ns/1ps
// Outside world of the two pins: pull-ups plus a source that pulls them low
module pin_partner (
    input wire logic clk,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic counter_pin_level,
    output logic int_level
);
    logic counter_pin_low = 1'b0; // Source pulls the counter pin low
    logic int_low = 1'b0; // Source pulls the interrupt pin low
    // The block owns the counter pin while it drives; else pull-up or source
    assign counter_pin_level = pin_oe ? pin_out : ~counter_pin_low;
    assign int_level = ~int_low;
    // Low for w cycles then high for w; short w gives a prompt edge train
    task automatic pulse_counter_pin(input int w);
        @(posedge clk);
        counter_pin_low <= 1'b1;
        repeat (w) @(posedge clk);
        counter_pin_low <= 1'b0;
        repeat (w) @(posedge clk);
    endtask : pulse_counter_pin
    // Same shape on the interrupt pin
    task automatic pulse_int(input int w);
        @(posedge clk);
        int_low <= 1'b1;
        repeat (w) @(posedge clk);
        int_low <= 1'b0;
        repeat (w) @(posedge clk);
    endtask : pulse_int
endmodule : pin_partner

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 1'b0; // System clock
    logic rst_n = 1'b0; // Reset, active low
    logic [7:0] addr = 8'h00; // Register address
    logic [7:0] wdata = 8'h00; // Write data
    logic wr = 1'b0, rd = 1'b0, take = 1'b0, software_break_instruction = 1'b0, stop_oscillator_instruction = 1'b0, mclr = 1'b0; // Strobes
    logic mset = 1'b0, en = 1'b1; // Mask set strobe and clock enable
    logic [7:0] rdata; // Read data
    logic pout, poe, irq, strobe, mask, hold, counter_pin_lvl, int_lvl; // Observed levels
    logic [15:0] vec; // Vector address
    int error_cnt = 0; // Mismatches
    int checks_done = 0; // Comparisons
    int i; // Loop index
    time t0; // Start of a measured interval
    logic [7:0] ra [5] = '{8'hFC, 8'hFD, 8'hFE, 8'hFF, 8'h10}; // Reset-read addresses
    logic [7:0] re [5] = '{8'hFF, 8'h01, 8'h00, 8'h00, 8'h00}; // Their reset values
    logic [7:0] cfg [2] = '{8'h20, 8'h0C}; // Stop bit set; width mode with pin high
    always #5 sys_clk = ~sys_clk;
    timer_irq_unit u_timer_irq_unit (.SYS_CLK(sys_clk), .RST_N(rst_n), .CLK_EN(en),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .COUNTER_PIN_IN(counter_pin_lvl), .COUNTER_PIN_OUT(pout), .COUNTER_PIN_OE(poe),
        .INT_PIN_IN(int_lvl), .IRQ_TAKE(take), .BREAK_EXEC(software_break_instruction), .STOP_EXEC(stop_oscillator_instruction),
        .MASK_SET(mset), .MASK_CLEAR(mclr), .IRQ_REQUEST(irq), .VECTOR_ADDR(vec),
        .VECTOR_STROBE(strobe), .MASK_FLAG(mask), .CORE_CLOCK_HOLD(hold));
    pin_partner u_pin_partner (.clk(sys_clk), .pin_out(pout), .pin_oe(poe),
        .counter_pin_level(counter_pin_lvl), .int_level(int_lvl));
    // Counts and reports one comparison
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One-cycle write strobe
    task automatic wrt(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wrt
    // One-cycle read; data stand only in the following cycle
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 check({8'h00, rdata}, {8'h00, e});
    endtask : rdc
    // Mask clear pulse, ends on an edge so timing below stays aligned
    task automatic clr_mask();
        @(posedge sys_clk);
        mclr <= 1'b1;
        @(posedge sys_clk);
        mclr <= 1'b0;
    endtask : clr_mask
    // Bounded wait for a pending request
    task automatic wait_irq();
        int n;
        n = 0;
        #1;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check({15'h0000, irq}, 16'h0001);
    endtask : wait_irq
    // Bounded wait for the vector strobe, then vector and mask
    task automatic vec_wait(input logic [15:0] e);
        int n;
        n = 0;
        #1;
        while (strobe !== 1'b1 && n < 4) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check({15'h0000, strobe}, 16'h0001);
        check(vec, e);
        check({15'h0000, mask}, 16'h0001);
    endtask : vec_wait
    // Accept the pending request
    task automatic take_irq(input logic [15:0] e);
        @(posedge sys_clk);
        take <= 1'b1;
        @(posedge sys_clk);
        take <= 1'b0;
        vec_wait(e);
    endtask : take_irq
    // Interval between request rises must be 96 clocks; v2 differs when two fire
    task automatic period(input logic [15:0] v1, input logic [15:0] v2);
        clr_mask();
        wait_irq();
        t0 = $time;
        repeat (60) @(posedge sys_clk);
        take_irq(v1);
        clr_mask();
        if (v2 !== v1) begin
            take_irq(v2);
            clr_mask();
        end
        wait_irq();
        check(16'(($time - t0) / 10), 16'h0060);
        take_irq(v1);
    endtask : period
    // Wait for the pulse output to change level
    task automatic wait_flip();
        logic lv;
        int n;
        #1;
        lv = pout;
        n = 0;
        while (pout === lv && n < 300) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask : wait_flip
    // Verdict and end of run
    task automatic complete_run();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    // Longest case is the stop wake-up of about 4100 clocks
    initial begin
        repeat (40000) @(posedge sys_clk);
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        vec_wait(timer_irq_pkg::VEC_RESET);
        for (i = 0; i < 5; i++) rdc(ra[i], re[i]);
        wrt(8'hFE, 8'hFF);
        rdc(8'hFE, 8'h51);
        wrt(8'hFF, 8'hFF);
        rdc(8'hFF, 8'hEC);
        wrt(8'hFF, 8'h00);
        // Pin requests while masked, then priority on acceptance
        wrt(8'hFE, 8'h41);
        u_pin_partner.pulse_counter_pin(20);
        u_pin_partner.pulse_int(20);
        check({15'h0000, irq}, 16'h0000);
        rdc(8'hFE, 8'hC3);
        clr_mask();
        wait_irq();
        take_irq(timer_irq_pkg::VEC_COUNTER_PIN);
        rdc(8'hFE, 8'h43);
        wrt(8'hFE, 8'h41);
        rdc(8'hFE, 8'h41);
        // Set and clear of the mask in one cycle: set wins
        clr_mask();
        @(posedge sys_clk);
        mset <= 1'b1;
        mclr <= 1'b1;
        @(posedge sys_clk);
        mset <= 1'b0;
        mclr <= 1'b0;
        #1 check({15'h0000, mask}, 16'h0001);
        @(posedge sys_clk);
        software_break_instruction <= 1'b1;
        @(posedge sys_clk);
        software_break_instruction <= 1'b0;
        vec_wait(timer_irq_pkg::VEC_INT);
        // Timer X interval: 2 ticks of 16 clocks per count, 3 counts
        wrt(8'hFC, 8'h01);
        wrt(8'hFD, 8'h02);
        wrt(8'hFE, 8'h10);
        period(timer_irq_pkg::VEC_TX, timer_irq_pkg::VEC_TX);
        wrt(8'hFE, 8'h00);
        wrt(8'hFF, 8'h04);
        wait_flip();
        check({15'h0000, poe}, 16'h0001);
        t0 = $time;
        wait_flip();
        check(16'(($time - t0) / 10), 16'h0060);
        // Clock enable low for 200 cycles stretches the next half period by 200
        t0 = $time;
        @(posedge sys_clk);
        en <= 1'b0;
        repeat (200) @(posedge sys_clk);
        en <= 1'b1;
        wait_flip();
        check(16'(($time - t0) / 10), 16'h0128);
        // Timers 1 and 2 fire together; prescaler 3 ticks of 16 clocks
        wrt(8'hF9, 8'h01);
        wrt(8'hFA, 8'h01);
        wrt(8'hFB, 8'h01);
        wrt(8'hFF, 8'hC0);
        period(timer_irq_pkg::VEC_T1, timer_irq_pkg::VEC_T2);
        // Event counting: first event empties the prescaler, second zeroes timer X
        wrt(8'hFF, 8'h08);
        wrt(8'hFC, 8'h01);
        wrt(8'hFD, 8'h01);
        wrt(8'hFE, 8'h00);
        u_pin_partner.pulse_counter_pin(20);
        rdc(8'hFE, 8'h80);
        u_pin_partner.pulse_counter_pin(20);
        rdc(8'hFE, 8'hA0);
        for (i = 0; i < 2; i++) begin
            wrt(8'hFF, cfg[i]);
            wrt(8'hFD, 8'h05);
            repeat (200) @(posedge sys_clk);
            rdc(8'hFD, 8'h05);
        end
        // Stop with width mode and pin high: only the forced divider can count
        wrt(8'hFE, 8'h01);
        @(posedge sys_clk);
        stop_oscillator_instruction <= 1'b1;
        @(posedge sys_clk);
        stop_oscillator_instruction <= 1'b0;
        rdc(8'hFC, 8'hFF);
        rdc(8'hFD, 8'h01);
        check({15'h0000, hold}, 16'h0001);
        u_pin_partner.pulse_int(20);
        i = 0;
        while (hold === 1'b1 && i < 10000) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        check({15'h0000, hold}, 16'h0000);
        rdc(8'hFE, 8'h23);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        vec_wait(timer_irq_pkg::VEC_RESET);
        for (i = 2; i < 4; i++) rdc(ra[i], re[i]);
        complete_run();
    end
endmodule : testbench
